// *** fbs_map.svh ***
// register map, field positions, limits and timing of the fieldbus slave port
`ifndef FBS_MAP_SVH
`define FBS_MAP_SVH

// slave function codes
`define FBS_FC_RD_HOLD 8'h03
`define FBS_FC_RD_INP 8'h04
`define FBS_FC_WR_ONE 8'h06
`define FBS_FC_WR_MULTI 8'h10
`define FBS_FC_RDWR 8'h17
// extra codes usable when acting as master
`define FBS_FC_RD_COIL 8'h01
`define FBS_FC_RD_DISC 8'h02
`define FBS_FC_WR_COIL 8'h05
`define FBS_FC_WR_COILS 8'h0f

`define FBS_EXC_FLAG 8'h80
`define FBS_EXC_FUNC 8'h01
`define FBS_EXC_ADDR 8'h02
`define FBS_EXC_VALUE 8'h03
`define FBS_BCAST_ADDR 8'h00

// frame limits in bytes, quantity limits in registers
`define FBS_MAX_MSG 9'h100
`define FBS_MIN_FRAME 9'h004
`define FBS_MAX_RD_QTY 16'h007d
`define FBS_MAX_WR_QTY 16'h007b
`define FBS_MAX_RW_WQTY 16'h0079

// register word addresses
`define FBS_A_MONEN0 16'h35e1
`define FBS_A_MONEN1 16'h35e3
`define FBS_A_FAIL0 16'h35ed
`define FBS_A_FAIL1 16'h35ee
`define FBS_A_ALARM0 16'h3661
`define FBS_A_ALARM1 16'h3662
`define FBS_A_VOLT_HI 16'h4a38
`define FBS_A_VOLT_LO 16'h4a39

// alarm register bit positions and monitor enable reset value
`define FBS_ALM_WARN 0
`define FBS_ALM_OVER 1
`define FBS_ALM_ALARM 2
`define FBS_ALM_FAIL 3
`define FBS_MONEN_RST 1'b0

// overload limits: 600 Vrms in 0.1 V steps, 7 Arms in mA
`define FBS_V_LIM 16'h1770
`define FBS_I_LIM 16'h1b58

// profile limits
`define FBS_PB_MAX_BYTES 8'h7f
`define FBS_PB_USER_LAST 8'h0f
`define FBS_PB_FACTORY_CNT 8'h04

// crc-16 with reflected polynomial
`define FBS_CRC_INIT 16'hffff
`define FBS_CRC_POLY 16'ha001

// timing
`define FBS_CLK_HZ 200000000
`define FBS_BAUD_DEF 19200
`define FBS_SILENCE_HALFBITS 77

`endif

// *** fbs_pkg.sv ***
// types of the fieldbus slave port
package fbs_pkg;
  typedef enum logic [3:0] {
    ST_RX, ST_CHECK, ST_WR, ST_RD, ST_EXC, ST_SEND, ST_CRC_LO, ST_CRC_HI, ST_DRAIN
  } fbs_state_t;
  typedef enum logic [2:0] {
    FBS_S8, FBS_U8, FBS_S16, FBS_U16, FBS_S32, FBS_U32, FBS_F32, FBS_F64
  } fbs_fmt_t;
endpackage : fbs_pkg

// *** fbs_crc_if.sv ***
// crc request and result between frame engine and crc unit
`timescale 1ns/100ps
interface fbs_crc_if;
  logic clr;
  logic en;
  logic [7:0] din;
  logic [15:0] crc;
  modport eng (output clr, output en, output din, input crc);
  modport calc (input clr, input en, input din, output crc);
endinterface : fbs_crc_if

// *** fbs_crc.sv ***
// byte-wide crc-16 accumulator
`timescale 1ns/100ps
`include "fbs_map.svh"
module fbs_crc
  import fbs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  fbs_crc_if.calc bus
);
  function automatic logic [15:0] fbs_crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int k = 0; k < 8; k++)
    begin
      r = r[0] ? ((r >> 1) ^ `FBS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : fbs_crc_step

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      bus.crc <= `FBS_CRC_INIT;
    else if (ce)
    begin
      if (bus.clr)
        bus.crc <= `FBS_CRC_INIT;
      else if (bus.en)
        bus.crc <= fbs_crc_step(bus.crc, bus.din);
    end
  end

  crc_clear_a: assert property (@(posedge mclk) disable iff (rst)
    ce && bus.clr |=> bus.crc == `FBS_CRC_INIT) else $error("crc not cleared");
endmodule : fbs_crc

// *** fbs_slave.sv ***
// rtu slave frame engine with alarm, overload, counters and profile helpers
`timescale 1ns/100ps
`include "fbs_map.svh"
module fbs_slave
  import fbs_pkg::*;
#(
  parameter int BAUD = `FBS_BAUD_DEF
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] slave_addr,
  input wire logic rx_in,
  output logic tx_out,
  output logic tx_drv_en,
  input wire logic [1:0] rcm_warn_in,
  input wire logic [1:0] rcm_over_in,
  input wire logic [1:0] rcm_fail_in,
  output logic [1:0] rcm_alarm,
  input wire logic [31:0] phase_one_to_neutral_in,
  input wire logic rms_valid,
  input wire logic [3:0][15:0] volt_rms_in,
  input wire logic [3:0][15:0] curr_rms_in,
  output logic overload,
  input wire logic cnt_reset,
  input wire logic [31:0] now_time,
  output logic [31:0] rx_count,
  output logic [31:0] tx_count,
  output logic [31:0] err_count,
  output logic [31:0] start_time,
  input wire logic [7:0] pb_profile_num,
  input wire logic [7:0] pb_profile_len,
  output logic pb_editable,
  output logic pb_factory,
  output logic pb_len_ok,
  input wire logic [31:0] pb_val_in,
  input wire fbs_fmt_t pb_fmt,
  input wire logic pb_big_endian,
  output logic [63:0] pb_val_out,
  input wire logic pb_dout_wr,
  input wire logic [7:0] pb_dout_data,
  output logic [7:0] dig_out,
  input wire logic [7:0] mst_fc,
  output logic mst_fc_ok
);
  localparam int BIT_CYC = `FBS_CLK_HZ / BAUD;
  localparam int SIL_CYC = BIT_CYC * `FBS_SILENCE_HALFBITS / 2;

  fbs_state_t st;
  logic [7:0] buf_mem [0:255];
  logic [8:0] rx_len, idx, tx_len;
  logic rx_bad;
  logic [15:0] rd_base, wr_base;
  logic [7:0] rd_cnt, wr_cnt, wr_dp, exc_code;
  logic [1:0] mon_en, fail_stat;
  logic [3:0] over_vec;
  fbs_crc_if crc_if ();

  fbs_crc u_crc (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .bus(crc_if)
  );

  // serial receiver: checks only the first stop bit so 1 or 2 are both accepted
  logic rx_busy, rx_stb, rx_ferr;
  logic [23:0] rx_tmr, sil_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_sh;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_busy <= 1'b0;
      rx_stb <= 1'b0;
      rx_ferr <= 1'b0;
      rx_tmr <= 24'h0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
    end
    else if (ce)
    begin
      rx_stb <= 1'b0;
      if (!rx_busy)
      begin
        if (!rx_in)
        begin
          rx_busy <= 1'b1;
          rx_tmr <= 24'(BIT_CYC / 2);
          rx_bit <= 4'h0;
        end
      end
      else if (rx_tmr != 24'h0)
        rx_tmr <= rx_tmr - 24'h1;
      else
      begin
        rx_tmr <= 24'(BIT_CYC - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_in)
          rx_busy <= 1'b0;
        else if (rx_bit == 4'h9)
        begin
          rx_busy <= 1'b0;
          rx_stb <= 1'b1;
          rx_ferr <= !rx_in;
        end
        else if (rx_bit != 4'h0)
          rx_sh <= {rx_in, rx_sh[7:1]};
      end
    end
  end

  // inter-frame silence of 3.5 characters closes a frame
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sil_cnt <= 24'h0;
    else if (ce)
    begin
      if (rx_busy || st != ST_RX)
        sil_cnt <= 24'h0;
      else if (sil_cnt != 24'(SIL_CYC))
        sil_cnt <= sil_cnt + 24'h1;
    end
  end
  logic frame_end;
  assign frame_end = (sil_cnt == 24'(SIL_CYC - 1)) && (rx_len != 9'h0);

  // serial transmitter: start, 8 data, 2 stop
  logic tx_busy, tx_load;
  logic [10:0] tx_sh;
  logic [3:0] tx_bit;
  logic [23:0] tx_tmr;
  logic [7:0] tx_byte;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_busy <= 1'b0;
      tx_sh <= 11'h7ff;
      tx_bit <= 4'h0;
      tx_tmr <= 24'h0;
    end
    else if (ce)
    begin
      if (tx_load)
      begin
        tx_busy <= 1'b1;
        tx_sh <= {2'b11, tx_byte, 1'b0};
        tx_bit <= 4'h0;
        tx_tmr <= 24'(BIT_CYC - 1);
      end
      else if (tx_busy)
      begin
        if (tx_tmr != 24'h0)
          tx_tmr <= tx_tmr - 24'h1;
        else
        begin
          tx_tmr <= 24'(BIT_CYC - 1);
          tx_sh <= {1'b1, tx_sh[10:1]};
          tx_bit <= tx_bit + 4'h1;
          if (tx_bit == 4'ha)
            tx_busy <= 1'b0;
        end
      end
    end
  end
  assign tx_out = tx_sh[0];
  assign tx_drv_en = tx_busy;

  // request decode, fields taken high byte first
  logic [7:0] fc;
  logic [15:0] f2, f4, f6, f8;
  logic frame_ok, ours, dec_known, dec_valid;
  assign fc = buf_mem[1];
  assign f2 = {buf_mem[2], buf_mem[3]};
  assign f4 = {buf_mem[4], buf_mem[5]};
  assign f6 = {buf_mem[6], buf_mem[7]};
  assign f8 = {buf_mem[8], buf_mem[9]};
  assign frame_ok = !rx_bad && rx_len >= `FBS_MIN_FRAME && crc_if.crc == 16'h0000;
  assign ours = buf_mem[0] == slave_addr && buf_mem[0] != `FBS_BCAST_ADDR;
  always_comb
  begin
    dec_known = 1'b1;
    dec_valid = 1'b0;
    case (fc)
      `FBS_FC_RD_HOLD, `FBS_FC_RD_INP:
        dec_valid = f4 != 16'h0 && f4 <= `FBS_MAX_RD_QTY && rx_len == 9'h008;
      `FBS_FC_WR_ONE:
        dec_valid = rx_len == 9'h008;
      `FBS_FC_WR_MULTI:
        dec_valid = f4 != 16'h0 && f4 <= `FBS_MAX_WR_QTY && {8'h0, buf_mem[6]} == {f4[14:0], 1'b0}
          && rx_len == 9'h009 + {1'b0, buf_mem[6]};
      `FBS_FC_RDWR:
        dec_valid = f4 != 16'h0 && f4 <= `FBS_MAX_RD_QTY && f8 != 16'h0
          && f8 <= `FBS_MAX_RW_WQTY && {8'h0, buf_mem[10]} == {f8[14:0], 1'b0}
          && rx_len == 9'h00d + {1'b0, buf_mem[10]};
      default:
        dec_known = 1'b0;
    endcase
  end

  // register access; the float spans two words, high word first
  logic [15:0] rd_addr, wr_addr, rd_data, wr_data;
  logic [8:0] rdi, dptr;
  logic rd_ok, wr_ok, wr_stb;
  assign rdi = idx - 9'h1;
  assign rd_addr = rd_base + {8'h0, rdi[8:1]};
  assign wr_addr = wr_base + {8'h0, idx[7:0]};
  assign dptr = {1'b0, wr_dp} + {idx[7:0], 1'b0};
  assign wr_data = {buf_mem[dptr[7:0]], buf_mem[dptr[7:0] + 8'h1]};
  assign wr_ok = wr_addr inside {`FBS_A_ALARM0, `FBS_A_ALARM1, `FBS_A_MONEN0, `FBS_A_MONEN1};
  assign wr_stb = st == ST_WR && wr_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    rd_data = 16'h0000;
    case (rd_addr)
      `FBS_A_ALARM0, `FBS_A_ALARM1:
      begin
        rd_data[`FBS_ALM_WARN] = rcm_warn_in[rd_addr[1]];
        rd_data[`FBS_ALM_OVER] = rcm_over_in[rd_addr[1]];
        rd_data[`FBS_ALM_ALARM] = rcm_alarm[rd_addr[1]];
        rd_data[`FBS_ALM_FAIL] = fail_stat[rd_addr[1]];
      end
      `FBS_A_FAIL0: rd_data[0] = fail_stat[0];
      `FBS_A_FAIL1: rd_data[0] = fail_stat[1];
      `FBS_A_MONEN0: rd_data[0] = mon_en[0];
      `FBS_A_MONEN1: rd_data[0] = mon_en[1];
      `FBS_A_VOLT_HI: rd_data = phase_one_to_neutral_in[31:16];
      `FBS_A_VOLT_LO: rd_data = phase_one_to_neutral_in[15:0];
      default: rd_ok = 1'b0;
    endcase
  end

  // frame engine
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st <= ST_RX;
      idx <= 9'h0;
      tx_len <= 9'h0;
      rd_base <= 16'h0;
      wr_base <= 16'h0;
      rd_cnt <= 8'h0;
      wr_cnt <= 8'h0;
      wr_dp <= 8'h0;
      exc_code <= 8'h0;
    end
    else if (ce)
    begin
      case (st)
        ST_RX:
          if (frame_end)
            st <= ST_CHECK;
        ST_CHECK:
        begin
          idx <= 9'h0;
          rd_base <= f2;
          rd_cnt <= f4[7:0];
          wr_base <= (fc == `FBS_FC_RDWR) ? f6 : f2;
          wr_cnt <= (fc == `FBS_FC_RDWR) ? f8[7:0] : (fc == `FBS_FC_WR_MULTI) ? f4[7:0] : 8'h1;
          wr_dp <= (fc == `FBS_FC_RDWR) ? 8'h0b : (fc == `FBS_FC_WR_MULTI) ? 8'h07 : 8'h04;
          if (!frame_ok || !ours)
            st <= ST_RX;
          else if (!dec_known)
          begin
            exc_code <= `FBS_EXC_FUNC;
            st <= ST_EXC;
          end
          else if (!dec_valid)
          begin
            exc_code <= `FBS_EXC_VALUE;
            st <= ST_EXC;
          end
          else if (fc == `FBS_FC_RD_HOLD || fc == `FBS_FC_RD_INP)
            st <= ST_RD;
          else
            st <= ST_WR;
          if (fc == `FBS_FC_WR_ONE || fc == `FBS_FC_WR_MULTI)
            rd_cnt <= 8'h0;
        end
        ST_WR:
          if (!wr_ok)
          begin
            exc_code <= `FBS_EXC_ADDR;
            idx <= 9'h0;
            st <= ST_EXC;
          end
          else if (idx[7:0] == wr_cnt - 8'h1)
          begin
            idx <= 9'h0;
            tx_len <= 9'h006;
            st <= (rd_cnt != 8'h0) ? ST_RD : ST_SEND;
          end
          else
            idx <= idx + 9'h1;
        ST_RD:
          if (idx != 9'h0 && !rd_ok)
          begin
            exc_code <= `FBS_EXC_ADDR;
            idx <= 9'h0;
            st <= ST_EXC;
          end
          else if (idx == {rd_cnt, 1'b0})
          begin
            idx <= 9'h0;
            tx_len <= 9'h003 + {rd_cnt, 1'b0};
            st <= ST_SEND;
          end
          else
            idx <= idx + 9'h1;
        ST_EXC:
          if (idx[0])
          begin
            idx <= 9'h0;
            tx_len <= 9'h003;
            st <= ST_SEND;
          end
          else
            idx <= 9'h1;
        ST_SEND:
          if (tx_load)
          begin
            idx <= (idx == tx_len - 9'h1) ? 9'h0 : idx + 9'h1;
            if (idx == tx_len - 9'h1)
              st <= ST_CRC_LO;
          end
        ST_CRC_LO:
          if (tx_load)
            st <= ST_CRC_HI;
        ST_CRC_HI:
          if (tx_load)
            st <= ST_DRAIN;
        ST_DRAIN:
          if (!tx_busy)
            st <= ST_RX;
        default:
          st <= ST_RX;
      endcase
    end
  end

  // crc is fed on reception and transmission; crc travels low byte first
  assign tx_load = (st == ST_SEND || st == ST_CRC_LO || st == ST_CRC_HI) && !tx_busy;
  assign tx_byte = (st == ST_CRC_LO) ? crc_if.crc[7:0] :
                   (st == ST_CRC_HI) ? crc_if.crc[15:8] : buf_mem[idx[7:0]];
  assign crc_if.clr = st inside {ST_CHECK, ST_WR, ST_RD, ST_EXC, ST_DRAIN};
  assign crc_if.en = (st == ST_RX && rx_stb) || (st == ST_SEND && tx_load);
  assign crc_if.din = (st == ST_RX) ? rx_sh : buf_mem[idx[7:0]];

  // frame buffer: request in, reply built over it
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      if (st == ST_RX && rx_stb && !rx_len[8])
        buf_mem[rx_len[7:0]] <= rx_sh;
      else if (st == ST_RD)
        buf_mem[8'h02 + idx[7:0]] <= (idx == 9'h0) ? {rd_cnt[6:0], 1'b0} :
          (rdi[0] ? rd_data[7:0] : rd_data[15:8]);
      else if (st == ST_EXC)
        buf_mem[idx[0] ? 8'h02 : 8'h01] <= idx[0] ? exc_code : (fc | `FBS_EXC_FLAG);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_len <= 9'h0;
      rx_bad <= 1'b0;
    end
    else if (ce)
    begin
      // also cleared on leaving check, so a dropped frame is never judged twice
      if (st != ST_RX)
      begin
        rx_len <= 9'h0;
        rx_bad <= 1'b0;
      end
      else if (st == ST_RX && rx_stb)
      begin
        if (rx_len == `FBS_MAX_MSG || rx_ferr)
          rx_bad <= 1'b1;
        else
          rx_len <= rx_len + 9'h1;
      end
    end
  end

  // packet counters; the clear command wins over a same-cycle count
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_count <= 32'h0;
      tx_count <= 32'h0;
      err_count <= 32'h0;
      start_time <= 32'h0;
    end
    else if (ce)
    begin
      if (cnt_reset)
      begin
        rx_count <= 32'h0;
        tx_count <= 32'h0;
        err_count <= 32'h0;
        start_time <= now_time;
      end
      else
      begin
        if (st == ST_CHECK && frame_ok && ours)
          rx_count <= rx_count + 32'h1;
        if (st == ST_CHECK && !frame_ok)
          err_count <= err_count + 32'h1;
        if (st == ST_CRC_HI && tx_load)
          tx_count <= tx_count + 32'h1;
      end
    end
  end

  // residual inputs and overload per channel
  genvar g;
  for (g = 0; g < 4; g++)
  begin : g_chan
    assign over_vec[g] = volt_rms_in[g] > `FBS_V_LIM || curr_rms_in[g] > `FBS_I_LIM;
    if (g < 2)
    begin : g_rcm
      localparam logic [15:0] A_EN = (g == 0) ? `FBS_A_MONEN0 : `FBS_A_MONEN1;
      localparam logic [15:0] A_ALM = (g == 0) ? `FBS_A_ALARM0 : `FBS_A_ALARM1;
      assign fail_stat[g] = rcm_fail_in[g] & mon_en[g];
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          mon_en[g] <= `FBS_MONEN_RST;
          rcm_alarm[g] <= 1'b0;
        end
        else if (ce)
        begin
          if (wr_stb && wr_addr == A_EN)
            mon_en[g] <= wr_data[0];
          if (rcm_warn_in[g] || rcm_over_in[g] || fail_stat[g])
            rcm_alarm[g] <= 1'b1;
          else if (wr_stb && wr_addr == A_ALM)
            rcm_alarm[g] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      overload <= 1'b0;
    else if (ce && rms_valid)
      overload <= |over_vec;
  end

  // profile helpers
  function automatic logic [63:0] fbs_conv(input logic [31:0] v, input fbs_fmt_t f,
                                            input logic be);
    logic signed [31:0] sv;
    logic [63:0] raw, res;
    int nb;
    sv = v;
    nb = 4;
    raw = {32'h0, v};
    case (f)
      FBS_S8: begin raw = 64'(sv > 127 ? 127 : sv < -128 ? -128 : sv); nb = 1; end
      FBS_U8: begin raw = 64'(sv > 255 ? 255 : sv < 0 ? 0 : sv); nb = 1; end
      FBS_S16: begin raw = 64'(sv > 32767 ? 32767 : sv < -32768 ? -32768 : sv); nb = 2; end
      FBS_U16: begin raw = 64'(sv > 65535 ? 65535 : sv < 0 ? 0 : sv); nb = 2; end
      FBS_U32: raw = 64'(sv < 0 ? 0 : sv);
      FBS_F64:
      begin
        nb = 8;
        if (v[30:23] == 8'h00)
          raw = {v[31], 63'h0};
        else if (v[30:23] == 8'hff)
          raw = {v[31], 11'h7ff, v[22:0], 29'h0};
        else
          raw = {v[31], {3'h0, v[30:23]} + 11'h380, v[22:0], 29'h0};
      end
      default: raw = {32'h0, v};
    endcase
    res = 64'h0;
    for (int k = 0; k < 8; k++)
    begin
      if (k < nb)
        res[8*k +: 8] = be ? raw[8*(nb-1-k) +: 8] : raw[8*k +: 8];
    end
    return res;
  endfunction : fbs_conv

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pb_editable <= 1'b0;
      pb_factory <= 1'b0;
      pb_len_ok <= 1'b0;
      pb_val_out <= 64'h0;
      dig_out <= 8'h00;
      mst_fc_ok <= 1'b0;
    end
    else if (ce)
    begin
      pb_editable <= pb_profile_num <= `FBS_PB_USER_LAST;
      pb_factory <= pb_profile_num < `FBS_PB_FACTORY_CNT;
      pb_len_ok <= pb_profile_len <= `FBS_PB_MAX_BYTES;
      pb_val_out <= fbs_conv(pb_val_in, pb_fmt, pb_big_endian);
      if (pb_dout_wr)
        dig_out <= pb_dout_data;
      mst_fc_ok <= mst_fc inside {`FBS_FC_RD_COIL, `FBS_FC_RD_DISC, `FBS_FC_RD_HOLD,
        `FBS_FC_RD_INP, `FBS_FC_WR_COIL, `FBS_FC_WR_ONE, `FBS_FC_WR_COILS,
        `FBS_FC_WR_MULTI, `FBS_FC_RDWR};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_reset_cmd;
    ce && cnt_reset;
  endsequence
  sequence s_cleared;
    rx_count == 32'h0 && err_count == 32'h0 && tx_count == 32'h0;
  endsequence
  cnt_clear_a: assert property (s_reset_cmd |=> s_cleared and (start_time == $past(now_time)))
    else $error("counter reset incomplete");
  bcast_drop_a: assert property (ce && st == ST_CHECK && buf_mem[0] == 8'h00 |=> st == ST_RX)
    else $error("broadcast frame acted on");
  bad_crc_a: assert property (ce && !cnt_reset && st == ST_CHECK && !frame_ok
    |=> st == ST_RX && err_count == $past(err_count) + 32'h1)
    else $error("faulty frame not dropped and counted");
  bad_fc_a: assert property (ce && st == ST_CHECK && frame_ok && ours && !dec_known
    |=> st == ST_EXC)
    else $error("unsupported code not rejected");
  overload_follow_a: assert property (ce && rms_valid |=> overload == $past(|over_vec))
    else $error("overload does not follow");
  alarm_set_a: assert property (ce && (rcm_warn_in[0] || rcm_over_in[0] || fail_stat[0])
    |=> rcm_alarm[0]) else $error("alarm not set");
  alarm_hold_a: assert property (rcm_alarm[1] && !(wr_stb && wr_addr == `FBS_A_ALARM1)
    |=> rcm_alarm[1]) else $error("alarm dropped without ack");
  tx_len_a: assert property (st == ST_SEND |-> tx_len <= 9'h0fe)
    else $error("reply too long");
  rx_len_a: assert property (rx_len <= `FBS_MAX_MSG) else $error("request buffer overrun");
  monen_wr_a: assert property (ce && wr_stb && wr_addr == `FBS_A_MONEN0
    |=> mon_en[0] == $past(wr_data[0])) else $error("monitor enable not written");
  stop_bits_a: assert property (tx_busy && tx_bit >= 4'h9 |-> tx_out)
    else $error("stop bit low");
endmodule : fbs_slave

// *** fbs_master.sv ***
// rtu master model on the rs485 link
`timescale 1ns/100ps
module fbs_master #(parameter int BIT = 10)
(
  input wire logic mclk,
  input wire logic tx_out,
  output logic rx_in
);
  logic [7:0] r [$];
  initial rx_in = 1'b1;
  function automatic logic [15:0] crc(input logic [7:0] d [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (d[i])
    begin
      c = c ^ {8'h00, d[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc
  // lsb first, 8 data bits, no parity, 2 stop bits
  task automatic put(input logic [7:0] b);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rx_in = f[i];
      repeat (BIT) @(negedge mclk);
    end
  endtask : put
  // gap first, so the previous reply has closed; crc low byte first
  task automatic send(input logic [7:0] f [$], input logic bad);
    logic [15:0] c;
    c = crc(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    repeat (400) @(negedge mclk);
    foreach (f[i]) put(f[i]);
  endtask : send
  task automatic get(input int n);
    int t;
    logic [7:0] b;
    r = {};
    for (int k = 0; k < n; k++)
    begin
      t = 0;
      while (tx_out === 1'b1 && t < 9000)
      begin
        @(negedge mclk);
        t++;
      end
      if (t == 9000) return;
      repeat (BIT + BIT / 2) @(negedge mclk);
      for (int i = 0; i < 8; i++)
      begin
        b[i] = tx_out;
        repeat (BIT) @(negedge mclk);
      end
      r.push_back(b);
    end
  endtask : get
endmodule : fbs_master

// *** fbs_slave_tb.sv ***
// self-checking bench of the fieldbus slave port
`timescale 1ns/100ps
module fbs_slave_tb;
  import fbs_pkg::*;
  logic mclk = 0, rst = 1, rms_valid = 0, cnt_reset = 0, pb_dout_wr = 0, rx, tx;
  logic [1:0] warn = 0, over = 0, fail = 0, alarm;
  logic [3:0][15:0] volt = 0, curr = 0;
  logic [7:0] pnum = 0, plen = 8'h10, dout, fc = 0;
  logic overload, ed, fac, lok, fc_ok;
  logic [31:0] rxc, txc, errc, st, cyc = 0;
  logic ce = 1, be = 1, drv;
  logic [7:0] sa = 8'h01, pdd = 8'ha5;
  logic [31:0] vin = 32'h0000_0005, now = 32'h0000_1234;
  logic [63:0] pbo;
  fbs_fmt_t fmt = FBS_S8;
  int failures = 0, compares = 0;
  always #2.5 mclk = ~mclk;
  fbs_master #(.BIT(10)) fbs_master_i (.mclk(mclk), .tx_out(tx), .rx_in(rx));
  fbs_slave #(.BAUD(20000000)) fbs_slave_i (.mclk(mclk), .rst(rst), .ce(ce),
    .slave_addr(sa), .rx_in(rx), .tx_out(tx), .tx_drv_en(drv), .rcm_warn_in(warn),
    .rcm_over_in(over), .rcm_fail_in(fail), .rcm_alarm(alarm),
    .phase_one_to_neutral_in(32'h4366_8000), .rms_valid(rms_valid), .volt_rms_in(volt),
    .curr_rms_in(curr), .overload(overload), .cnt_reset(cnt_reset),
    .now_time(now), .rx_count(rxc), .tx_count(txc), .err_count(errc),
    .start_time(st), .pb_profile_num(pnum), .pb_profile_len(plen), .pb_editable(ed),
    .pb_factory(fac), .pb_len_ok(lok), .pb_val_in(vin), .pb_fmt(fmt),
    .pb_big_endian(be), .pb_val_out(pbo), .pb_dout_wr(pb_dout_wr),
    .pb_dout_data(pdd), .dig_out(dout), .mst_fc(fc), .mst_fc_ok(fc_ok));
  task automatic chk(input string n, input logic [95:0] s, input logic [95:0] e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      failures++;
      test_done;
    end
  end
  initial
  begin
    tick(4);
    rst = 0;
    chk("idle", {drv, tx}, 2'b01);
    fbs_master_i.send('{8'h01, 8'h03, 8'h4a, 8'h38, 8'h00, 8'h02}, 1'b0);
    fbs_master_i.get(9);
    chk("rd len", fbs_master_i.r.size(), 9);
    chk("rd data", {fbs_master_i.r[2], fbs_master_i.r[3], fbs_master_i.r[4]}, 24'h044366);
    chk("rd crc", fbs_master_i.crc(fbs_master_i.r), 0);
    chk("s8", pbo, 64'h5);
    fbs_master_i.send('{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    fbs_master_i.get(5);
    chk("exc", {fbs_master_i.r[1], fbs_master_i.r[2]}, 16'h8201);
    fbs_master_i.send('{8'h00, 8'h03, 8'h4a, 8'h38, 8'h00, 8'h02}, 1'b0);
    fbs_master_i.get(1);
    chk("bcast", fbs_master_i.r.size(), 0);
    fbs_master_i.send('{8'h01, 8'h03, 8'h4a, 8'h38, 8'h00, 8'h02}, 1'b1);
    fbs_master_i.get(1);
    chk("badcrc", {fbs_master_i.r.size(), errc[3:0]}, 1);
    chk("counts", {rxc[3:0], txc[3:0]}, 8'h22);
    warn = 2'b11;
    tick(3);
    warn = 0;
    tick(3);
    chk("alarm", alarm, 2'b11);
    fbs_master_i.send('{8'h01, 8'h06, 8'h36, 8'h61, 8'h00, 8'h00}, 1'b0);
    fbs_master_i.get(8);
    chk("ack", alarm, 2'b10);
    sa = 8'h07;
    fbs_master_i.send('{8'h07, 8'h10, 8'h35, 8'he1, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01}, 1'b0);
    fbs_master_i.get(8);
    chk("wr multi", {fbs_master_i.r[0], fbs_master_i.r[1], fbs_master_i.r[5]}, 24'h071001);
    fail = 2'b01;
    fbs_master_i.send('{8'h07, 8'h04, 8'h35, 8'hed, 8'h00, 8'h01}, 1'b0);
    fbs_master_i.get(7);
    chk("fail st", {fbs_master_i.r[2], fbs_master_i.r[3], fbs_master_i.r[4]}, 24'h020001);
    fail = 0;
    volt[2] = 16'h1771;
    rms_valid = 1;
    tick(1);
    rms_valid = 0;
    tick(2);
    chk("ovl", overload, 1);
    volt[2] = 16'h1770;
    rms_valid = 1;
    tick(1);
    rms_valid = 0;
    tick(2);
    chk("ovl off", overload, 0);
    cnt_reset = 1;
    tick(1);
    cnt_reset = 0;
    tick(2);
    chk("clr", {rxc, errc, st}, 96'h1234);
    pnum = 8'h0f;
    plen = 8'h80;
    fc = 8'h0f;
    pb_dout_wr = 1;
    tick(1);
    pb_dout_wr = 0;
    tick(2);
    chk("pb", {ed, lok, fc_ok, dout}, 11'h5a5);
    pnum = 8'h10;
    fc = 8'h07;
    tick(3);
    chk("pb2", {ed, fc_ok}, 0);
    pnum = 8'h03;
    tick(3);
    chk("pb3", {ed, fac}, 2'b11);
    fmt = FBS_F64;
    vin = 32'h3f80_0000;
    tick(3);
    chk("f64 be", pbo, 64'hf03f);
    be = 0;
    tick(3);
    chk("f64 le", pbo, 64'h3ff0_0000_0000_0000);
    ce = 0;
    pdd = 8'h3c;
    pb_dout_wr = 1;
    tick(1);
    pb_dout_wr = 0;
    ce = 1;
    tick(2);
    chk("ce hold", dout, 8'ha5);
    test_done;
  end
endmodule : fbs_slave_tb
